// [verilog/lbcr_top.sv]
// Configuration registers of a three-bank LED backlight driver.
// Assumes a serial slave on CLK_IN delivers byte writes and reads,
// and the zone result comes from the averager on the same clock.
`timescale 1ns/1ns
`include "lbcr_cfg.svh"
module lbcr_top (
  input  wire logic                        CLK_IN,
  input  wire logic                        SYS_RST_IN,
  input  wire logic                        CE_IN,
  input  wire logic                        REG_WR_IN,
  input  wire logic                        REG_RD_IN,
  input  wire logic [7:0]                  REG_ADDR_IN,
  input  wire logic [7:0]                  REG_WDATA_IN,
  input  wire logic [2:0]                  ZONE_IN,
  output logic [7:0]                       REG_RDATA_OUT,
  output logic                             REG_RVALID_OUT,
  output lbcr_pkg::lbcr_bank_out_type      BANK_A_OUT,
  output lbcr_pkg::lbcr_bank_out_type      BANK_B_OUT,
  output lbcr_pkg::lbcr_bank_out_type      BANK_C_OUT,
  output logic [2:0]                       SINK_FEEDBACK_OUT,
  output lbcr_pkg::lbcr_pulldown_type      SENSOR1_PULLDOWN_OUT,
  output lbcr_pkg::lbcr_pulldown_type      SENSOR2_PULLDOWN_OUT
);
  import lbcr_pkg::*;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [7:0]        bank_a_full_scale_current;
  lbcr_bank_cfg_type bank_b_brightness_config;
  logic [7:0]        bank_b_full_scale_current;
  lbcr_bank_cfg_type bank_c_brightness_config;
  logic [7:0]        bank_c_full_scale_current;
  logic [7:0]        sink_feedback_enable;
  logic [7:0]        bank_enable;
  logic [7:0]        sensor1_pulldown_select;
  logic [7:0]        sensor2_pulldown_select;
  logic [2:0]        target_b;
  logic [2:0]        target_c;
  logic [7:0]        next_rdata;
  logic              wr;

  assign wr = CE_IN && REG_WR_IN;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [9:0] fs_tenth(input logic [7:0] code);
    fs_tenth = `LBCR_FS_BASE_TENTH + `LBCR_FS_STEP_TENTH * {5'd0, code[4:0]};
  endfunction

  function automatic lbcr_pulldown_type pd_view(input logic [7:0] sel);
    pd_view.code   = sel[4:0];
    pd_view.high_z = (sel[4:0] == 5'h00);
  endfunction

  // ----------------------------------------
  // Bank configuration registers
  // ----------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      bank_b_brightness_config <= lbcr_bank_cfg_type'(5'(`LBCR_RST_CFG));
      bank_c_brightness_config <= lbcr_bank_cfg_type'(5'(`LBCR_RST_CFG));
    end else if (wr) begin
      if (REG_ADDR_IN == `LBCR_ADDR_B_CFG) begin
        bank_b_brightness_config <= lbcr_bank_cfg_type'(REG_WDATA_IN[4:0]);
      end
      if (REG_ADDR_IN == `LBCR_ADDR_C_CFG) begin
        bank_c_brightness_config <= lbcr_bank_cfg_type'(REG_WDATA_IN[4:0]);
      end
    end
  end

  // ----------------------------------------
  // Full-scale current registers
  // ----------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      bank_a_full_scale_current <= `LBCR_RST_FS;
      bank_b_full_scale_current <= `LBCR_RST_FS;
      bank_c_full_scale_current <= `LBCR_RST_FS;
    end else if (wr) begin
      if (REG_ADDR_IN == `LBCR_ADDR_A_FS) begin
        bank_a_full_scale_current <= REG_WDATA_IN & `LBCR_MASK_CODE5;
      end
      if (REG_ADDR_IN == `LBCR_ADDR_B_FS) begin
        bank_b_full_scale_current <= REG_WDATA_IN & `LBCR_MASK_CODE5;
      end
      if (REG_ADDR_IN == `LBCR_ADDR_C_FS) begin
        bank_c_full_scale_current <= REG_WDATA_IN & `LBCR_MASK_CODE5;
      end
    end
  end

  // ----------------------------------------
  // Feedback and bank enables
  // ----------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      sink_feedback_enable <= `LBCR_RST_FB_EN;
      bank_enable          <= `LBCR_RST_BANK_EN;
    end else if (wr) begin
      if (REG_ADDR_IN == `LBCR_ADDR_FB_EN) begin
        sink_feedback_enable <= REG_WDATA_IN & `LBCR_MASK_BITS3;
      end
      if (REG_ADDR_IN == `LBCR_ADDR_BANK_EN) begin
        bank_enable <= REG_WDATA_IN & `LBCR_MASK_BITS3;
      end
    end
  end

  // ----------------------------------------
  // Sensor pulldown selects
  // ----------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      sensor1_pulldown_select <= `LBCR_RST_PD;
      sensor2_pulldown_select <= `LBCR_RST_PD;
    end else if (wr) begin
      if (REG_ADDR_IN == `LBCR_ADDR_PD1) begin
        sensor1_pulldown_select <= REG_WDATA_IN & `LBCR_MASK_CODE5;
      end
      if (REG_ADDR_IN == `LBCR_ADDR_PD2) begin
        sensor2_pulldown_select <= REG_WDATA_IN & `LBCR_MASK_CODE5;
      end
    end
  end

  // ----------------------------------------
  // Read back, unused bits and addresses give zero
  // ----------------------------------------
  always_comb begin
    unique case (REG_ADDR_IN)
      `LBCR_ADDR_A_FS:    next_rdata = bank_a_full_scale_current;
      `LBCR_ADDR_B_CFG:   next_rdata = {3'h0, bank_b_brightness_config};
      `LBCR_ADDR_B_FS:    next_rdata = bank_b_full_scale_current;
      `LBCR_ADDR_C_CFG:   next_rdata = {3'h0, bank_c_brightness_config};
      `LBCR_ADDR_C_FS:    next_rdata = bank_c_full_scale_current;
      `LBCR_ADDR_FB_EN:   next_rdata = sink_feedback_enable;
      `LBCR_ADDR_BANK_EN: next_rdata = bank_enable;
      `LBCR_ADDR_PD1:     next_rdata = sensor1_pulldown_select;
      `LBCR_ADDR_PD2:     next_rdata = sensor2_pulldown_select;
      default:            next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      REG_RDATA_OUT  <= 8'h00;
      REG_RVALID_OUT <= 1'b0;
    end else if (CE_IN) begin
      REG_RVALID_OUT <= REG_RD_IN;
      if (REG_RD_IN) begin
        REG_RDATA_OUT <= next_rdata;
      end
    end
  end

  // ----------------------------------------
  // Active target selection for banks B and C
  // ----------------------------------------
  lbcr_zone_sel u_zone_b (
    .cfg_in     (bank_b_brightness_config),
    .zone_in    (ZONE_IN),
    .target_out (target_b)
  );

  lbcr_zone_sel u_zone_c (
    .cfg_in     (bank_c_brightness_config),
    .zone_in    (ZONE_IN),
    .target_out (target_c)
  );

  // ----------------------------------------
  // Settings to the analog side
  // ----------------------------------------
  always_comb begin
    BANK_A_OUT.enable      = bank_enable[0];
    BANK_A_OUT.host_ctrl   = 1'b1;
    BANK_A_OUT.linear      = 1'b0;
    BANK_A_OUT.target      = `LBCR_ZONE_TOP;
    BANK_A_OUT.fs_code     = bank_a_full_scale_current[4:0];
    BANK_A_OUT.fs_tenth_ma = fs_tenth(bank_a_full_scale_current);
    BANK_B_OUT.enable      = bank_enable[1];
    BANK_B_OUT.host_ctrl   = bank_b_brightness_config.host_ctrl;
    BANK_B_OUT.linear      = bank_b_brightness_config.linear;
    BANK_B_OUT.target      = target_b;
    BANK_B_OUT.fs_code     = bank_b_full_scale_current[4:0];
    BANK_B_OUT.fs_tenth_ma = fs_tenth(bank_b_full_scale_current);
    BANK_C_OUT.enable      = bank_enable[2];
    BANK_C_OUT.host_ctrl   = bank_c_brightness_config.host_ctrl;
    BANK_C_OUT.linear      = bank_c_brightness_config.linear;
    BANK_C_OUT.target      = target_c;
    BANK_C_OUT.fs_code     = bank_c_full_scale_current[4:0];
    BANK_C_OUT.fs_tenth_ma = fs_tenth(bank_c_full_scale_current);
    SINK_FEEDBACK_OUT      = sink_feedback_enable[2:0];
    SENSOR1_PULLDOWN_OUT   = pd_view(sensor1_pulldown_select);
    SENSOR2_PULLDOWN_OUT   = pd_view(sensor2_pulldown_select);
  end

endmodule

// [verilog/lbcr_cfg.svh]
// Constants of the LED bank configuration register block.
// Assumes inclusion by the top module and the zone selector only.
`ifndef LBCR_CFG_SVH
`define LBCR_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LBCR_ADDR_A_FS      8'h17
`define LBCR_ADDR_B_CFG     8'h18
`define LBCR_ADDR_B_FS      8'h19
`define LBCR_ADDR_C_CFG     8'h1a
`define LBCR_ADDR_C_FS      8'h1b
`define LBCR_ADDR_FB_EN     8'h1c
`define LBCR_ADDR_BANK_EN   8'h1d
`define LBCR_ADDR_PD1       8'h20
`define LBCR_ADDR_PD2       8'h21

// ----------------------------------------
// Field positions and write masks
// ----------------------------------------
`define LBCR_CFG_HOST_BIT   0
`define LBCR_CFG_LIN_BIT    1
`define LBCR_CFG_PTR_LSB    2
`define LBCR_CFG_PTR_MSB    4
`define LBCR_MASK_CFG       8'h1f
`define LBCR_MASK_CODE5     8'h1f
`define LBCR_MASK_BITS3     8'h07

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LBCR_RST_CFG        8'h11
`define LBCR_RST_FS         8'h13
`define LBCR_RST_FB_EN      8'h07
`define LBCR_RST_BANK_EN    8'h00
`define LBCR_RST_PD         8'h00

// ----------------------------------------
// Current scale, in tenths of a milliampere, and top zone index
// ----------------------------------------
`define LBCR_FS_BASE_TENTH  10'd50
`define LBCR_FS_STEP_TENTH  10'd8
`define LBCR_ZONE_TOP       3'd4

`endif

// [verilog/lbcr_pkg.sv]
// Types of the LED bank configuration register block.
// Assumes the constants header is on the include path.
package lbcr_pkg;

  // ----------------------------------------
  // Bank configuration fields
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] pointer;
    logic       linear;
    logic       host_ctrl;
  } lbcr_bank_cfg_type;

  // ----------------------------------------
  // Per-bank settings handed to the analog side
  // ----------------------------------------
  typedef struct packed {
    logic       enable;
    logic       host_ctrl;
    logic       linear;
    logic [2:0] target;
    logic [4:0] fs_code;
    logic [9:0] fs_tenth_ma;
  } lbcr_bank_out_type;

  // ----------------------------------------
  // Sensor pulldown settings
  // ----------------------------------------
  typedef struct packed {
    logic [4:0] code;
    logic       high_z;
  } lbcr_pulldown_type;

endpackage

// [verilog/lbcr_zone_sel.sv]
// Selects the active brightness target index of one bank.
// Assumes its inputs come from flip-flops on the same clock.
`timescale 1ns/1ns
`include "lbcr_cfg.svh"
module lbcr_zone_sel (
  input  wire lbcr_pkg::lbcr_bank_cfg_type cfg_in,
  input  wire logic [2:0]                  zone_in,
  output logic [2:0]                       target_out
);
  import lbcr_pkg::*;

  // ----------------------------------------
  // Code to index, top bit set means index 4
  // ----------------------------------------
  function automatic logic [2:0] decode_idx(input logic [2:0] code);
    decode_idx = code[2] ? `LBCR_ZONE_TOP : {1'b0, code[1:0]};
  endfunction

  // ----------------------------------------
  // Pointer under host control, zone otherwise
  // ----------------------------------------
  always_comb begin
    if (cfg_in.host_ctrl) begin
      target_out = decode_idx(cfg_in.pointer);
    end else begin
      target_out = decode_idx(zone_in);
    end
  end

endmodule

// [verification/lbcr_monitor.sv]
// Checker for the LED bank configuration registers.
// Assumes it is bound to lbcr_top and sees its ports only.
`timescale 1ns/1ns
module lbcr_monitor (
  input wire logic                       CLK_IN,
  input wire logic                       SYS_RST_IN,
  input wire logic                       CE_IN,
  input wire logic                       REG_WR_IN,
  input wire logic                       REG_RD_IN,
  input wire logic [7:0]                 REG_ADDR_IN,
  input wire logic [7:0]                 REG_WDATA_IN,
  input wire logic [2:0]                 ZONE_IN,
  input wire logic [7:0]                 REG_RDATA_OUT,
  input wire logic                       REG_RVALID_OUT,
  input wire lbcr_pkg::lbcr_bank_out_type BANK_A_OUT,
  input wire lbcr_pkg::lbcr_bank_out_type BANK_B_OUT,
  input wire lbcr_pkg::lbcr_bank_out_type BANK_C_OUT,
  input wire logic [2:0]                 SINK_FEEDBACK_OUT,
  input wire lbcr_pkg::lbcr_pulldown_type SENSOR1_PULLDOWN_OUT,
  input wire lbcr_pkg::lbcr_pulldown_type SENSOR2_PULLDOWN_OUT
);
  import lbcr_pkg::*;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  sequence s_wr(a);
    CE_IN && REG_WR_IN && REG_ADDR_IN == a;
  endsequence
  chk_read_answer: assert property (
    CE_IN && REG_RD_IN |=> REG_RVALID_OUT && REG_RDATA_OUT[7:5] == 3'h0) else $error("read answer");
  chk_cfg_b_fields: assert property (s_wr(8'h18) |=>
    BANK_B_OUT.host_ctrl == $past(REG_WDATA_IN[0]) && BANK_B_OUT.linear == $past(REG_WDATA_IN[1]))
    else $error("bank b config fields");
  chk_cfg_c_fields: assert property (s_wr(8'h1a) |=>
    BANK_C_OUT.host_ctrl == $past(REG_WDATA_IN[0]) && BANK_C_OUT.linear == $past(REG_WDATA_IN[1]))
    else $error("bank c config fields");
  chk_zone_follow: assert property (!BANK_C_OUT.host_ctrl |->
    BANK_C_OUT.target == (ZONE_IN[2] ? 3'h4 : ZONE_IN)) else $error("zone target");
  chk_target_range: assert property (BANK_B_OUT.target <= 3'h4) else $error("target range");
  chk_fs_scale: assert property (
    BANK_A_OUT.fs_tenth_ma == 10'h32 + 10'h8 * BANK_A_OUT.fs_code) else $error("full scale");
  chk_fs_write: assert property (s_wr(8'h1b) |=>
    BANK_C_OUT.fs_code == $past(REG_WDATA_IN[4:0])) else $error("full scale write");
  chk_fb_write: assert property (s_wr(8'h1c) |=>
    SINK_FEEDBACK_OUT == $past(REG_WDATA_IN[2:0])) else $error("feedback write");
  chk_bank_enable: assert property (s_wr(8'h1d) |=> {BANK_C_OUT.enable,
    BANK_B_OUT.enable, BANK_A_OUT.enable} == $past(REG_WDATA_IN[2:0])) else $error("enable");
  chk_pd_separate: assert property (s_wr(8'h20) |=>
    SENSOR1_PULLDOWN_OUT.code == $past(REG_WDATA_IN[4:0]) && $stable(SENSOR2_PULLDOWN_OUT))
    else $error("pulldown select");
  chk_pd_highz: assert property (
    SENSOR2_PULLDOWN_OUT.high_z == (SENSOR2_PULLDOWN_OUT.code == 5'h00)) else $error("high z");
endmodule

// [verification/lbcr_host_model.sv]
// Host that writes and reads the configuration registers.
// Assumes one byte access at a time, driven at the falling edge.
`timescale 1ns/1ns
module lbcr_host_model (
  input  wire logic       clk_in,
  output logic            wr_out,
  output logic            rd_out,
  output logic [7:0]      addr_out,
  output logic [7:0]      wdata_out
);
  // ----------------------------------------
  // Byte access
  // ----------------------------------------
  initial {wr_out, rd_out, addr_out, wdata_out} = 18'h0;
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    wr_out    = w;
    rd_out    = !w;
    addr_out  = a;
    wdata_out = d;
    @(negedge clk_in);
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    addr_out  = ~a;
    wdata_out = ~d;
  endtask
endmodule

// [verification/tb_top.sv]
// Self-checking bench of the LED bank configuration registers.
// Assumes the host model and the checker are compiled beside it.
`timescale 1ns/1ns
module tb_top;
  import lbcr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [2:0] zone = 3'h0;
  logic wr, rd, rvalid;
  logic [7:0] addr, wdata, rdata, r;
  logic [2:0] fb;
  lbcr_bank_out_type bank_a, bank_b, bank_c;
  lbcr_pulldown_type pd1, pd2;
  logic [7:0] exp_q[$];
  int err_count = 0;
  int total_checks = 0;
  int seed = 68;
  int cycles = 0;
  localparam logic [7:0] addr_t [9] = '{8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h20, 8'h21};
  localparam logic [7:0] rst_t [9] = '{8'h13, 8'h11, 8'h13, 8'h11, 8'h13, 8'h07, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] mask_t [9] = '{8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h07, 8'h07, 8'h1f, 8'h1f};
  lbcr_host_model lbcr_host_model_inst (.clk_in(clk), .wr_out(wr), .rd_out(rd), .addr_out(addr),
    .wdata_out(wdata));
  lbcr_top lbcr_top_inst (.CLK_IN(clk), .SYS_RST_IN(rst), .CE_IN(ce), .REG_WR_IN(wr),
    .REG_RD_IN(rd), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .ZONE_IN(zone),
    .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid), .BANK_A_OUT(bank_a), .BANK_B_OUT(bank_b),
    .BANK_C_OUT(bank_c), .SINK_FEEDBACK_OUT(fb), .SENSOR1_PULLDOWN_OUT(pd1),
    .SENSOR2_PULLDOWN_OUT(pd2));
  // ----------------------------------------
  // Clock, timeout, compares and accesses
  // ----------------------------------------
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic cmp_out(input string n, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cmp_rd(input logic [7:0] e, input logic [7:0] s);
    cmp_out("read data", {8'h00, e}, {8'h00, s});
  endtask
  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) cmp_out("spare answer", 16'h0, 16'h1);
      else cmp_rd(exp_q.pop_front(), rdata);
    end
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    lbcr_host_model_inst.access(1'b1, a, d);
  endtask
  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    lbcr_host_model_inst.access(1'b0, a, 8'h00);
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 9; i++) rd_exp(addr_t[i], rst_t[i]);
    rd_exp(8'h1e, 8'h00);
    cmp_out("reset target", bank_b.target, 3'h4);
    cmp_out("reset scale", bank_c.fs_tenth_ma, 10'hca);
    cmp_out("reset high z", {pd1.high_z, pd2.high_z}, 2'h3);
    $display("test reset values done");
    repeat (3) for (int i = 0; i < 9; i++) begin
      r = 8'($random(seed));
      wr_reg(addr_t[i], r);
      rd_exp(addr_t[i], r & mask_t[i]);
    end
    $display("test random writes done");
    for (int p = 0; p < 8; p++) begin
      wr_reg(8'h18, {3'h0, p[2:0], 2'b01});
      cmp_out("host target", bank_b.target, p[2] ? 3'h4 : p[2:0]);
      zone = 3'($random(seed));
      wr_reg(8'h1a, {3'h0, p[2:0], 2'b10});
      cmp_out("zone target", bank_c.target, zone[2] ? 3'h4 : zone);
      cmp_out("curve", {bank_b.linear, bank_c.linear, bank_c.host_ctrl}, 3'h2);
    end
    $display("test pointer done");
    wr_reg(8'h17, 8'hff);
    wr_reg(8'h1b, 8'h00);
    cmp_out("scale top", bank_a.fs_tenth_ma, 10'h12a);
    cmp_out("scale base", bank_c.fs_tenth_ma, 10'h32);
    wr_reg(8'h20, 8'h01);
    wr_reg(8'h21, 8'h00);
    cmp_out("pulldowns", {pd1, pd2}, {5'h01, 1'b0, 5'h00, 1'b1});
    wr_reg(8'h1d, 8'h05);
    wr_reg(8'h1c, 8'h02);
    cmp_out("enables", {bank_c.enable, bank_b.enable, bank_a.enable, fb}, 6'h2a);
    $display("test fields done");
    ce = 1'b0;
    wr_reg(8'h1d, 8'h02);
    lbcr_host_model_inst.access(1'b0, 8'h1d, 8'h00);
    ce = 1'b1;
    rd_exp(8'h1d, 8'h05);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    rd_exp(8'h1d, 8'h00);
    cmp_out("scale code", bank_a.fs_code, 5'h13);
    repeat (3) @(negedge clk);
    cmp_out("pending reads", 16'h0, 16'(exp_q.size()));
    $display("test enable and reset done");
    complete_run();
  end
endmodule
bind lbcr_top lbcr_monitor lbcr_monitor_inst (.CLK_IN, .SYS_RST_IN, .CE_IN, .REG_WR_IN,
  .REG_RD_IN, .REG_ADDR_IN, .REG_WDATA_IN, .ZONE_IN, .REG_RDATA_OUT, .REG_RVALID_OUT,
  .BANK_A_OUT, .BANK_B_OUT, .BANK_C_OUT, .SINK_FEEDBACK_OUT, .SENSOR1_PULLDOWN_OUT,
  .SENSOR2_PULLDOWN_OUT);
